// ===== pkg/clksel_params.svh
// Offsets, field positions and reset values of the input clock switch selector
`ifndef CLKSEL_PARAMS_SVH
`define CLKSEL_PARAMS_SVH
// Register indices; byte address is four times the index
`define IDX_SWITCH_CTRL 12'h536
`define IDX_ALARM_MASKS 12'h537
`define IDX_PRIO_LO 12'h538
`define IDX_PRIO_HI 12'h539
`define IDX_HITLESS_CFG 12'h53A
`define IDX_THR_LO 12'h53B
`define IDX_THR_HI 12'h53C
`define IDX_CHOICE_CTRL 12'h52A
`define IDX_SEL_STATUS 12'h5F0
`define IDX_IRQ_STATUS 12'h5F1
`define IDX_IRQ_MASK 12'h5F2
// Field positions
`define POLICY_LSB 0
`define HITLESS_BIT 2
`define LOSMSK_LSB 0
`define OOFMSK_LSB 4
`define RANK_A_LSB 0
`define RANK_B_LSB 4
`define VARIANT_LSB 0
`define MEASCTL_LSB 2
`define SRC_REG_BIT 0
`define REG_SEL_LSB 1
// Interrupt bits
`define IRQ_SWITCHED 0
`define IRQ_NO_INPUT 1
// Reset values
`define RST_SWITCH_CTRL 8'h00
`define RST_ALARM_MASKS 8'h00
`define RST_PRIO_LO 8'h21
`define RST_PRIO_HI 8'h43
`define RST_HITLESS_CFG 8'h02
`define RST_THR_LO 8'h00
`define RST_THR_HI 2'h0
`define RST_CHOICE_CTRL 3'h0
`define RST_IRQ_MASK 2'h0
// Highest usable rank code
`define RANK_MAX 3'h4
`endif

// ===== pkg/clksel_pkg.sv
// Types of the input clock switch selector
package clksel_pkg;
  typedef enum logic [1:0] {
    POL_MANUAL = 2'h0,
    POL_NONREVERT = 2'h1,
    POL_REVERT = 2'h2,
    POL_RESERVED = 2'h3
  } switch_policy_t;
  // Gray coded along tracking -> holdover
  typedef enum logic [1:0] {
    ST_TRACK = 2'h0,
    ST_HOLD = 2'h1
  } sel_state_t;
  typedef struct packed {
    logic found;
    logic [1:0] idx;
  } pick_t;
  typedef struct packed {
    logic [3:0] signal_loss_alarm;
    logic [3:0] freq_fault_alarm;
  } alarms_t;
  typedef struct packed {
    logic [3:0] loss_m;
    logic [3:0] loss_s;
    logic [3:0] freq_m;
    logic [3:0] freq_s;
    logic [1:0] pin_m;
    logic [1:0] pin_s;
    logic [7:0] switch_ctrl;
    logic [7:0] alarm_masks;
    logic [7:0] prio_lo;
    logic [7:0] prio_hi;
    logic [7:0] hitless_cfg;
    logic [7:0] thr_lo;
    logic [1:0] thr_hi;
    logic [2:0] choice_ctrl;
    logic [1:0] active;
    sel_state_t state;
    logic [1:0] irq_st;
    logic [1:0] irq_msk;
    logic [31:0] rdata;
  } state_t;
endpackage : clksel_pkg

// ===== hdl/input_clock_switch_select.sv
// Reference input selector with alarm masks, ranks and APB registers
// How it works
// - Policy field: manual, non-revertive, revertive, reserved
// - Hitless bit 0 gives glitchless, no buildout
// - Hitless bit 1 enables phase buildout
// - Four loss masks; 1 removes that alarm
// - Four frequency masks; 1 removes that alarm
// - Selection outcome drives the holdover request
// - Three-bit rank per input; 5-7 reserved
// - Revertive mode picks lowest rank available; non-revertive only when active is ineligible
// - Equal ranks resolved by input order 0..3
// - Ten-bit phase limit over two registers
// - Manual select field picks inputs 0..3
// - Source bit picks pins or register select
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/100ps
`include "clksel_params.svh"

module input_clock_switch_select (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire clksel_pkg::alarms_t alarms,
  input wire logic [1:0] pin_choice,
  input wire logic zero_delay_on,
  output logic [1:0] active_input,
  output logic phase_buildout_on,
  output logic holdover_request,
  output logic [1:0] hitless_variant,
  output logic [1:0] phase_meas_ctrl,
  output logic [9:0] phase_meas_limit,
  output logic irq
);

  // ---------------------------------------------
  // Helpers
  // ---------------------------------------------
  function automatic logic rank_ok(input logic [2:0] code);
    rank_ok = (code != 3'h0) && (code <= `RANK_MAX);
  endfunction : rank_ok

  function automatic logic hit(input logic [31:0] addr, input logic [11:0] idx);
    hit = (addr == {18'h0, idx, 2'h0});
  endfunction : hit

  function automatic logic mapped(input logic [31:0] addr);
    mapped = hit(addr, `IDX_SWITCH_CTRL) || hit(addr, `IDX_ALARM_MASKS) ||
             hit(addr, `IDX_PRIO_LO) || hit(addr, `IDX_PRIO_HI) ||
             hit(addr, `IDX_HITLESS_CFG) || hit(addr, `IDX_THR_LO) ||
             hit(addr, `IDX_THR_HI) || hit(addr, `IDX_CHOICE_CTRL) ||
             hit(addr, `IDX_SEL_STATUS) || hit(addr, `IDX_IRQ_STATUS) ||
             hit(addr, `IDX_IRQ_MASK);
  endfunction : mapped

  // Lowest rank wins, lower index first on a tie
  function automatic clksel_pkg::pick_t best_pick(input logic [11:0] ranks,
                                                  input logic [3:0] ok);
    clksel_pkg::pick_t p;
    logic [2:0] r;
    p = '0;
    r = 3'h7;
    for (int i = 0; i < 4; i++)
    begin
      if (ok[i] && (!p.found || ranks[i*3 +: 3] < r))
      begin
        p.found = 1'b1;
        p.idx = 2'(i);
        r = ranks[i*3 +: 3];
      end
    end
    best_pick = p;
  endfunction : best_pick

  // ---------------------------------------------
  // State
  // ---------------------------------------------
  clksel_pkg::state_t s_r;
  clksel_pkg::state_t s_nxt;

  logic [3:0] avail;
  logic [3:0] eligible;
  logic [11:0] ranks;
  clksel_pkg::pick_t best;
  clksel_pkg::switch_policy_t policy;
  logic [1:0] manual_sel;
  logic [1:0] want;
  logic want_ok;
  logic setup;
  logic wr_acc;
  logic [1:0] irq_set;

  // ---------------------------------------------
  // Next state
  // ---------------------------------------------

  always_comb
  begin
    s_nxt = s_r;
    irq_set = 2'h0;
    // Alarm and pin synchronisers
    s_nxt.loss_m = alarms.signal_loss_alarm;
    s_nxt.loss_s = s_r.loss_m;
    s_nxt.freq_m = alarms.freq_fault_alarm;
    s_nxt.freq_s = s_r.freq_m;
    s_nxt.pin_m = pin_choice;
    s_nxt.pin_s = s_r.pin_m;
    avail = ~((s_r.loss_s & ~s_r.alarm_masks[`LOSMSK_LSB +: 4]) |
              (s_r.freq_s & ~s_r.alarm_masks[`OOFMSK_LSB +: 4]));
    ranks = {s_r.prio_hi[`RANK_B_LSB +: 3], s_r.prio_hi[`RANK_A_LSB +: 3],
             s_r.prio_lo[`RANK_B_LSB +: 3], s_r.prio_lo[`RANK_A_LSB +: 3]};
    for (int i = 0; i < 4; i++)
    begin
      eligible[i] = avail[i] && rank_ok(ranks[i*3 +: 3]);
    end
    best = best_pick(ranks, eligible);
    manual_sel = s_r.choice_ctrl[`SRC_REG_BIT] ?
                 s_r.choice_ctrl[`REG_SEL_LSB +: 2] : s_r.pin_s;
    policy = clksel_pkg::switch_policy_t'(s_r.switch_ctrl[`POLICY_LSB +: 2]);
    want = s_r.active;
    want_ok = 1'b1;
    case (policy)
      clksel_pkg::POL_MANUAL:
      begin
        want = manual_sel;
        want_ok = avail[manual_sel];
      end
      clksel_pkg::POL_NONREVERT:
      begin
        if (eligible[s_r.active])
        begin
          want = s_r.active;
        end
        else
        begin
          want = best.found ? best.idx : s_r.active;
        end
        want_ok = best.found;
      end
      clksel_pkg::POL_REVERT:
      begin
        want = best.found ? best.idx : s_r.active;
        want_ok = best.found;
      end
      default:
      begin
        want = s_r.active;
        want_ok = eligible[s_r.active];
      end
    endcase
    s_nxt.active = want;
    if (want != s_r.active)
    begin
      irq_set[`IRQ_SWITCHED] = 1'b1;
    end
    case (s_r.state)
      clksel_pkg::ST_TRACK:
      begin
        if (!want_ok)
        begin
          s_nxt.state = clksel_pkg::ST_HOLD;
          irq_set[`IRQ_NO_INPUT] = 1'b1;
        end
      end
      clksel_pkg::ST_HOLD:
      begin
        if (want_ok)
        begin
          s_nxt.state = clksel_pkg::ST_TRACK;
        end
      end
      default:
      begin
        s_nxt.state = clksel_pkg::ST_HOLD;
      end
    endcase
    // APB slave, zero wait states
    setup = psel && !penable;
    wr_acc = psel && penable && pwrite;
    if (setup)
    begin
      s_nxt.rdata = 32'h0;
      if (hit(paddr, `IDX_SWITCH_CTRL))
        s_nxt.rdata[7:0] = s_r.switch_ctrl;
      if (hit(paddr, `IDX_ALARM_MASKS))
        s_nxt.rdata[7:0] = s_r.alarm_masks;
      if (hit(paddr, `IDX_PRIO_LO))
        s_nxt.rdata[7:0] = s_r.prio_lo;
      if (hit(paddr, `IDX_PRIO_HI))
        s_nxt.rdata[7:0] = s_r.prio_hi;
      if (hit(paddr, `IDX_HITLESS_CFG))
        s_nxt.rdata[7:0] = s_r.hitless_cfg;
      if (hit(paddr, `IDX_THR_LO))
        s_nxt.rdata[7:0] = s_r.thr_lo;
      if (hit(paddr, `IDX_THR_HI))
        s_nxt.rdata[1:0] = s_r.thr_hi;
      if (hit(paddr, `IDX_CHOICE_CTRL))
        s_nxt.rdata[2:0] = s_r.choice_ctrl;
      if (hit(paddr, `IDX_SEL_STATUS))
        s_nxt.rdata[7:0] = {avail, zero_delay_on,
                            s_r.state == clksel_pkg::ST_HOLD, s_r.active};
      if (hit(paddr, `IDX_IRQ_STATUS))
        s_nxt.rdata[1:0] = s_r.irq_st;
      if (hit(paddr, `IDX_IRQ_MASK))
        s_nxt.rdata[1:0] = s_r.irq_msk;
    end
    if (wr_acc)
    begin
      if (hit(paddr, `IDX_SWITCH_CTRL))
        s_nxt.switch_ctrl = pwdata[7:0];
      if (hit(paddr, `IDX_ALARM_MASKS))
        s_nxt.alarm_masks = pwdata[7:0];
      if (hit(paddr, `IDX_PRIO_LO))
        s_nxt.prio_lo = pwdata[7:0];
      if (hit(paddr, `IDX_PRIO_HI))
        s_nxt.prio_hi = pwdata[7:0];
      if (hit(paddr, `IDX_HITLESS_CFG))
        s_nxt.hitless_cfg = pwdata[7:0];
      if (hit(paddr, `IDX_THR_LO))
        s_nxt.thr_lo = pwdata[7:0];
      if (hit(paddr, `IDX_THR_HI))
        s_nxt.thr_hi = pwdata[1:0];
      if (hit(paddr, `IDX_CHOICE_CTRL))
        s_nxt.choice_ctrl = pwdata[2:0];
      if (hit(paddr, `IDX_IRQ_MASK))
        s_nxt.irq_msk = pwdata[1:0];
      if (hit(paddr, `IDX_IRQ_STATUS))
        s_nxt.irq_st = s_r.irq_st & ~pwdata[1:0];
    end
    // New events win over a clear
    s_nxt.irq_st = s_nxt.irq_st | irq_set;
  end

  // ---------------------------------------------
  // Registers
  // ---------------------------------------------

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_r <= '0;
      s_r.switch_ctrl <= `RST_SWITCH_CTRL;
      s_r.alarm_masks <= `RST_ALARM_MASKS;
      s_r.prio_lo <= `RST_PRIO_LO;
      s_r.prio_hi <= `RST_PRIO_HI;
      s_r.hitless_cfg <= `RST_HITLESS_CFG;
      s_r.thr_lo <= `RST_THR_LO;
      s_r.thr_hi <= `RST_THR_HI;
      s_r.choice_ctrl <= `RST_CHOICE_CTRL;
      s_r.irq_msk <= `RST_IRQ_MASK;
      s_r.state <= clksel_pkg::ST_TRACK;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // ---------------------------------------------
  // Outputs
  // ---------------------------------------------
  assign prdata = s_r.rdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped(paddr);
  assign active_input = s_r.active;
  assign phase_buildout_on = s_r.switch_ctrl[`HITLESS_BIT];
  assign holdover_request = (s_r.state == clksel_pkg::ST_HOLD);
  assign hitless_variant = s_r.hitless_cfg[`VARIANT_LSB +: 2];
  assign phase_meas_ctrl = s_r.hitless_cfg[`MEASCTL_LSB +: 2];
  assign phase_meas_limit = {s_r.thr_hi, s_r.thr_lo};
  assign irq = |(s_r.irq_st & s_r.irq_msk);

endmodule : input_clock_switch_select

// ===== dv/clksel_monitor.sv
// Assertion checker for the input clock switch selector
`timescale 1ns/100ps
`include "clksel_params.svh"
module clksel_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire clksel_pkg::alarms_t alarms,
  input wire logic [1:0] pin_choice,
  input wire logic zero_delay_on,
  input wire logic [1:0] active_input,
  input wire logic phase_buildout_on,
  input wire logic holdover_request,
  input wire logic [1:0] hitless_variant,
  input wire logic [1:0] phase_meas_ctrl,
  input wire logic [9:0] phase_meas_limit,
  input wire logic irq
);
  // --------
  // Checks
  // --------
  localparam int a_sw = 4 * `IDX_SWITCH_CTRL;
  localparam int a_hc = 4 * `IDX_HITLESS_CFG;
  localparam int a_tl = 4 * `IDX_THR_LO;
  localparam int a_th = 4 * `IDX_THR_HI;
  logic wr;
  logic [31:0] wd_r;
  logic [1:0] quiet_r;
  assign wr = psel && penable && pwrite && pready;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      wd_r <= 32'h0;
      quiet_r <= 2'h0;
    end
    else
    begin
      wd_r <= pwdata;
      if (wr || $changed(alarms) || $changed(pin_choice))
        quiet_r <= 2'h0;
      else if (quiet_r != 2'h3)
        quiet_r <= quiet_r + 2'h1;
    end
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  buildout_bit_a: assert property (wr && paddr == a_sw |=> phase_buildout_on == wd_r[2])
    else $error("buildout mismatch");
  limit_low_a: assert property (wr && paddr == a_tl |=> phase_meas_limit[7:0] == wd_r[7:0])
    else $error("limit low mismatch");
  limit_high_a: assert property (wr && paddr == a_th |=> phase_meas_limit[9:8] == wd_r[1:0])
    else $error("limit high mismatch");
  limit_cause_a: assert property ($changed(phase_meas_limit) |-> $past(wr)
    && ($past(paddr) == a_tl || $past(paddr) == a_th)) else $error("limit moved alone");
  variant_store_a: assert property (wr && paddr == a_hc |=> hitless_variant == wd_r[1:0]
    && phase_meas_ctrl == wd_r[3:2]) else $error("variant mismatch");
  select_settle_a: assert property (quiet_r == 2'h3 |-> $stable(active_input)
    && $stable(holdover_request)) else $error("selection late");
  read_width_a: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  unmapped_zero_a: assert property (pslverr |-> psel && penable && prdata == 32'h0)
    else $error("bad error response");
  unmapped_err_a: assert property (psel && penable && paddr == 32'h1FFC |-> pslverr)
    else $error("missing bus error");
  mapped_ok_a: assert property (psel && penable && paddr == a_sw |-> !pslverr)
    else $error("spurious bus error");
  ready_high_a: assert property (psel && penable |-> pready)
    else $error("access not ready");
endmodule : clksel_monitor

// ===== dv/testbench.sv
// Self-checking bench for the input clock switch selector
`timescale 1ns/100ps
`include "clksel_params.svh"
module testbench;
  // --------
  // Bench
  // --------
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
  logic pready, pslverr, phase_buildout_on, holdover_request, irq, zero_delay_on = 1'h0;
  logic [1:0] pin_choice = 2'h0, active_input, hitless_variant, phase_meas_ctrl, cur, best;
  logic [9:0] phase_meas_limit;
  clksel_pkg::alarms_t alarms = 8'h00;
  int n_errors = 0, checked = 0, seed = 32'h2EF9EF14, i, k;
  logic [31:0] exp_q[$];
  logic [2:0] rk[4];
  logic [7:0] msk, plo, phi, cc, ctl;
  logic [3:0] av, el;
  logic found, hold;
  logic [11:0] ri[10] = '{`IDX_SWITCH_CTRL, `IDX_ALARM_MASKS, `IDX_PRIO_LO, `IDX_PRIO_HI,
    `IDX_HITLESS_CFG, `IDX_THR_LO, `IDX_THR_HI, `IDX_CHOICE_CTRL, `IDX_IRQ_MASK, `IDX_SEL_STATUS};
  logic [7:0] rv[10] = '{`RST_SWITCH_CTRL, `RST_ALARM_MASKS, `RST_PRIO_LO, `RST_PRIO_HI,
    `RST_HITLESS_CFG, `RST_THR_LO, 8'(`RST_THR_HI), 8'(`RST_CHOICE_CTRL),
    8'(`RST_IRQ_MASK), 8'hF0};
  always #10 pclk = ~pclk;
  input_clock_switch_select u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .alarms(alarms), .pin_choice(pin_choice), .zero_delay_on(zero_delay_on),
    .active_input(active_input), .phase_buildout_on(phase_buildout_on),
    .holdover_request(holdover_request), .hitless_variant(hitless_variant),
    .phase_meas_ctrl(phase_meas_ctrl), .phase_meas_limit(phase_meas_limit), .irq(irq)
  );
  task automatic close_out;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic apb(input logic w, input logic [11:0] idx, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {18'h0, idx, 2'h0};
    pwdata <= d;
    if (!w)
      exp_q.push_back(d);
    @(posedge pclk);
    penable <= 1'h1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge pclk);
      if (pready === 1'h1)
        break;
    end
    n_errors += (n == 20);
    if (n == 20)
      close_out();
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  always @(posedge pclk)
    if (psel && penable && !pwrite && pready === 1'h1 && exp_q.size() > 0)
      cmp(prdata, exp_q.pop_front());
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    cmp({28'h0, hitless_variant, phase_meas_ctrl}, 32'h8);
    for (i = 0; i < 10; i++)
      apb(1'h0, ri[i], {24'h0, rv[i]});
    apb(1'h1, 12'h7FF, 32'hFF);
    apb(1'h0, 12'h7FF, 32'h0);
    apb(1'h1, `IDX_HITLESS_CFG, 32'h2);
    plo = 8'($random(seed));
    phi = 8'($random(seed)) & 8'h03;
    apb(1'h1, `IDX_THR_LO, {24'h0, plo});
    apb(1'h1, `IDX_THR_HI, {24'h0, phi});
    apb(1'h0, `IDX_THR_LO, {24'h0, plo});
    apb(1'h0, `IDX_THR_HI, {24'h0, phi});
    cur = 2'h0;
    for (i = 0; i < 40; i++)
    begin
      apb(1'h1, `IDX_CHOICE_CTRL, {29'h0, cur, 1'h1});
      apb(1'h1, `IDX_SWITCH_CTRL, 32'h0);
      msk = 8'($random(seed));
      plo = 8'($random(seed)) & 8'h77;
      phi = 8'($random(seed)) & 8'h77;
      cc = 8'($random(seed)) & 8'h07;
      ctl = 8'($random(seed)) & 8'h07;
      apb(1'h1, `IDX_ALARM_MASKS, {24'h0, msk});
      apb(1'h1, `IDX_PRIO_LO, {24'h0, plo});
      apb(1'h1, `IDX_PRIO_HI, {24'h0, phi});
      alarms <= 8'($random(seed));
      pin_choice <= 2'($random(seed));
      zero_delay_on <= 1'($random(seed)) & !ctl[2];
      repeat (4) @(posedge pclk);
      rk = '{plo[2:0], plo[6:4], phi[2:0], phi[6:4]};
      av = ~((alarms.signal_loss_alarm & ~msk[3:0]) | (alarms.freq_fault_alarm & ~msk[7:4]));
      found = 1'h0;
      best = 2'h0;
      for (k = 0; k < 4; k++)
      begin
        el[k] = av[k] && rk[k] != 3'h0 && rk[k] <= `RANK_MAX;
        if (el[k] && (!found || rk[k] < rk[best]))
          best = 2'(k);
        found = found | el[k];
      end
      apb(1'h1, `IDX_CHOICE_CTRL, {24'h0, cc});
      cur = cc[0] ? cc[2:1] : pin_choice;
      apb(1'h1, `IDX_SWITCH_CTRL, {24'h0, ctl});
      hold = (ctl[1:0] == 2'h0) ? !av[cur] : !el[cur];
      if (ctl[1:0] == 2'h2 || (ctl[1:0] == 2'h1 && hold))
      begin
        cur = found ? best : cur;
        hold = !found;
      end
      apb(1'h0, `IDX_SEL_STATUS, {24'h0, av, zero_delay_on, hold, cur});
      cmp({30'h0, active_input}, {30'h0, cur});
      cmp({31'h0, holdover_request}, {31'h0, hold});
      apb(1'h0, `IDX_SWITCH_CTRL, {24'h0, ctl});
      apb(1'h0, `IDX_ALARM_MASKS, {24'h0, msk});
      apb(1'h0, `IDX_PRIO_HI, {24'h0, phi});
    end
    alarms <= 8'h00;
    zero_delay_on <= 1'h0;
    apb(1'h1, `IDX_ALARM_MASKS, 32'h0);
    apb(1'h1, `IDX_PRIO_LO, 32'h21);
    apb(1'h1, `IDX_PRIO_HI, 32'h43);
    apb(1'h1, `IDX_SWITCH_CTRL, 32'h2);
    apb(1'h1, `IDX_IRQ_STATUS, 32'h3);
    apb(1'h1, `IDX_IRQ_MASK, 32'h1);
    alarms <= 8'h10;
    repeat (4) @(posedge pclk);
    cmp({31'h0, irq}, 32'h1);
    apb(1'h0, `IDX_IRQ_STATUS, 32'h1);
    apb(1'h1, `IDX_IRQ_MASK, 32'h0);
    apb(1'h0, `IDX_SEL_STATUS, 32'hE1);
    cmp({31'h0, irq}, 32'h0);
    apb(1'h1, `IDX_IRQ_STATUS, 32'h1);
    apb(1'h0, `IDX_IRQ_STATUS, 32'h0);
    alarms <= 8'hF0;
    repeat (4) @(posedge pclk);
    cmp({31'h0, holdover_request}, 32'h1);
    apb(1'h0, `IDX_IRQ_STATUS, 32'h2);
    apb(1'h0, `IDX_SEL_STATUS, 32'h05);
    close_out();
  end
endmodule : testbench
bind input_clock_switch_select clksel_monitor u_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .alarms(alarms), .pin_choice(pin_choice), .zero_delay_on(zero_delay_on),
  .active_input(active_input), .phase_buildout_on(phase_buildout_on),
  .holdover_request(holdover_request), .hitless_variant(hitless_variant),
  .phase_meas_ctrl(phase_meas_ctrl), .phase_meas_limit(phase_meas_limit), .irq(irq)
);
